// ---- design/mode_reg_pkg.sv ----
package mode_reg_pkg;

  // ******************************************************
  // Clock and basic latencies
  // ******************************************************
  localparam int CLK_PERIOD_PS = 10000;
  localparam int READ_LATENCY = 14;
  localparam int WRITE_LATENCY = 8;
  localparam int BURST_LENGTH = 16;
  localparam int REG_READ_BURST_LENGTH = 16;
  localparam int REG_READ_DATA_UI = 4;
  localparam int WRITE_PREAMBLE_CK = 2;
  localparam int TERMINATION_ON_LATENCY = 6;
  localparam int READ_TO_PRECHARGE_CLOCKS = 8;
  localparam int WRITE_RECOVERY_CLOCKS = 16;

  // ******************************************************
  // Analog times
  // ******************************************************
  localparam int STROBE_OUTPUT_DELAY_MAX_PS = 3500;
  localparam int WRITE_TO_READ_TURNAROUND_PS = 10000;
  localparam int ROW_TO_COLUMN_DELAY_PS = 18000;
  localparam int POWER_DOWN_EXIT_PS = 7500;
  localparam int READ_POSTAMBLE_TENTHS_CK = 5;
  localparam int TERMINATION_TURN_ON_MIN_PS = 1500;
  localparam int REG_READ_PERIOD_CK = 8;
  localparam int REG_WRITE_PERIOD_PS = 10000;
  localparam int REG_WRITE_PERIOD_MIN_CK = 10;
  localparam int REG_SET_DELAY_PS = 14000;
  localparam int REG_SET_DELAY_MIN_CK = 10;
  localparam int REG_WRITE_GAP_PS = 7500;
  localparam int REG_WRITE_GAP_MIN_CK = 8;
  localparam int REG_READ_EXTRA_CK = 3;

  function automatic int ceil_ck(input int ps);
    ceil_ck = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  endfunction

  function automatic int imax(input int a, input int b);
    imax = (a > b) ? a : b;
  endfunction

  // ******************************************************
  // Derived counts in clock cycles
  // ******************************************************
  localparam int STROBE_DELAY_CK = ceil_ck(STROBE_OUTPUT_DELAY_MAX_PS);
  localparam int TURNAROUND_CK = ceil_ck(WRITE_TO_READ_TURNAROUND_PS);
  localparam int ROW_TO_COLUMN_CK = imax(ceil_ck(ROW_TO_COLUMN_DELAY_PS), 1);
  localparam int POWER_DOWN_EXIT_CK = imax(ceil_ck(POWER_DOWN_EXIT_PS), 1);
  localparam int READ_POSTAMBLE_RD_CK = READ_POSTAMBLE_TENTHS_CK / 10;
  localparam int TERM_TURN_ON_RD_CK = TERMINATION_TURN_ON_MIN_PS / CLK_PERIOD_PS;
  localparam int REG_WRITE_PERIOD_CK = imax(ceil_ck(REG_WRITE_PERIOD_PS), REG_WRITE_PERIOD_MIN_CK);
  localparam int REG_SET_DELAY_CK = imax(ceil_ck(REG_SET_DELAY_PS), REG_SET_DELAY_MIN_CK);
  localparam int REG_WRITE_GAP_CK = imax(ceil_ck(REG_WRITE_GAP_PS), REG_WRITE_GAP_MIN_CK);
  localparam int REG_READ_EXTRA_DELAY_CK = ROW_TO_COLUMN_CK + REG_READ_EXTRA_CK;

  localparam int RR_AFTER_RD = BURST_LENGTH / 2;
  localparam int RR_AFTER_WR = WRITE_LATENCY + BURST_LENGTH / 2 + 1 + TURNAROUND_CK;
  localparam int WR_AFTER_RR_TERM_OFF = READ_LATENCY + STROBE_DELAY_CK + REG_READ_BURST_LENGTH / 2
                                        - WRITE_LATENCY + WRITE_PREAMBLE_CK + READ_POSTAMBLE_RD_CK;
  localparam int WR_AFTER_RR_TERM_ON = READ_LATENCY + STROBE_DELAY_CK + REG_READ_BURST_LENGTH / 2
                                       - TERMINATION_ON_LATENCY - TERM_TURN_ON_RD_CK
                                       + READ_POSTAMBLE_RD_CK + 1;
  localparam int RW_AFTER_RR = READ_LATENCY + STROBE_DELAY_CK + REG_READ_BURST_LENGTH / 2 + 3;
  localparam int RW_AFTER_RD = READ_LATENCY + BURST_LENGTH / 2 + STROBE_DELAY_CK
                               + READ_POSTAMBLE_RD_CK + REG_WRITE_GAP_CK;
  localparam int RW_AFTER_RDA = RW_AFTER_RD + READ_TO_PRECHARGE_CLOCKS - 8;
  localparam int RW_AFTER_WR = WRITE_LATENCY + 1 + BURST_LENGTH / 2 + REG_WRITE_GAP_CK;
  localparam int RW_AFTER_WRA = RW_AFTER_WR + WRITE_RECOVERY_CLOCKS;
  localparam int RR_AFTER_PDX = POWER_DOWN_EXIT_CK + REG_READ_EXTRA_DELAY_CK;
  localparam int REG_READ_BURST_CK = REG_READ_BURST_LENGTH / 2;

  // ******************************************************
  // Command encoding and spacing classes
  // ******************************************************
  typedef enum logic [3:0] {
    CMD_DES = 4'h0,
    CMD_ACT = 4'h1,
    CMD_PRE = 4'h2,
    CMD_RD  = 4'h3,
    CMD_RDA = 4'h4,
    CMD_WR  = 4'h5,
    CMD_WRA = 4'h6,
    CMD_REG_READ = 4'h7,
    CMD_REG_WRITE = 4'h8,
    CMD_PDE = 4'h9,
    CMD_PDX = 4'hA
  } cmd_t;

  localparam int K_RR = 0;
  localparam int K_RD = 1;
  localparam int K_WR = 2;
  localparam int K_RW = 3;
  localparam int K_ANY = 4;
  localparam int NUM_K = 5;

  localparam int NUM_REGS = 64;
  localparam logic [63:0] READ_ONLY_MASK = 64'h0000_0000_0000_01E1;
  localparam logic [5:0] REG_RESET_VALUE = 6'h00;

endpackage

// ---- design/mode_reg_link_if.sv ----
`timescale 1ns/1ns
interface mode_reg_link_if;
  logic cke;
  logic cs;
  logic [3:0] cmd;
  logic [5:0] ca;
  logic [7:0] dq;
  logic dq_oe;

  modport controller (output cke, output cs, output cmd, output ca, input dq, input dq_oe);
  modport device (input cke, input cs, input cmd, input ca, output dq, output dq_oe);
endinterface

// ---- design/mode_reg_controller.sv ----
`timescale 1ns/1ns
// Contract
// - Register read waits half burst after read
// - Register read waits write latency, half burst, turnaround
// - Turnaround counts from edge after last strobe
// - Only deselects during register read period
// - Register read waits exit time plus extra
// - Register read period at least eight clocks
// - Register writes spaced max(10ns, 10 clocks)
// - Reads/writes wait max(14ns, 10 clocks) after write
// - Only deselects during write period and delay
// - Writes to read-only registers are ignored
// - Register write address and data on six lines
// - Register access allowed idle or active, state kept
// - Read-to-write and read-to-register-write spacing, termination off
// - Read/write before register write spacing rules
// - Register read to write spacing, termination on
// - Other spacings same with termination enabled
// - Register read data first 4 UI, burst 16
module mode_reg_controller
  import mode_reg_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic req_valid_in,
  input wire logic [3:0] req_cmd_in,
  input wire logic [5:0] req_addr_in,
  input wire logic [5:0] req_data_in,
  input wire logic termination_enable_in,
  output logic req_ready_out,
  output logic rd_valid_out,
  output logic [7:0] rd_data_out,
  output logic power_down_out,
  mode_reg_link_if.controller link
);

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_REG_WRITE_DATA = 1'b1
  } ctl_state_t;

  // ******************************************************
  // Spacing tables
  // ******************************************************
  function automatic int class_of(input logic [3:0] cmd);
    case (cmd)
      CMD_RD, CMD_RDA: class_of = K_RD;
      CMD_WR, CMD_WRA: class_of = K_WR;
      CMD_REG_READ: class_of = K_RR;
      CMD_REG_WRITE: class_of = K_RW;
      default: class_of = K_ANY;
    endcase
  endfunction

  function automatic int req_delay(input logic [3:0] cmd, input logic term_on, input int k);
    req_delay = 0;
    case (cmd)
      CMD_RD: req_delay = (k == K_RR) ? RR_AFTER_RD : (k == K_RW) ? RW_AFTER_RD : 0;
      CMD_RDA: req_delay = (k == K_RR) ? RR_AFTER_RD : (k == K_RW) ? RW_AFTER_RDA : 0;
      CMD_WR: req_delay = (k == K_RR) ? RR_AFTER_WR : (k == K_RW) ? RW_AFTER_WR : 0;
      CMD_WRA: req_delay = (k == K_RR) ? RR_AFTER_WR : (k == K_RW) ? RW_AFTER_WRA : 0;
      CMD_REG_READ: begin
        case (k)
          K_RR, K_RD, K_ANY: req_delay = REG_READ_PERIOD_CK;
          K_WR: req_delay = term_on ? WR_AFTER_RR_TERM_ON : WR_AFTER_RR_TERM_OFF;
          default: req_delay = RW_AFTER_RR;
        endcase
      end
      CMD_REG_WRITE: begin
        case (k)
          // set delay before reads and writes
          K_RR, K_RD, K_WR: req_delay = REG_SET_DELAY_CK;
          K_RW: req_delay = REG_WRITE_PERIOD_CK;
          default: req_delay = imax(REG_SET_DELAY_CK, REG_WRITE_PERIOD_CK);
        endcase
      end
      CMD_PDX: begin
        if (k == K_RR) begin
          req_delay = RR_AFTER_PDX;
        end else begin
          req_delay = POWER_DOWN_EXIT_CK;
        end
      end
      default: req_delay = 0;
    endcase
  endfunction

  // ******************************************************
  // State
  // ******************************************************
  ctl_state_t state_q, state_d;
  logic pend_valid_q, pend_valid_d;
  logic [3:0] pend_cmd_q, pend_cmd_d;
  logic [5:0] pend_addr_q, pend_addr_d;
  logic [5:0] pend_data_q, pend_data_d;
  logic term_q, term_d;
  logic [5:0] reg_wdata_q, reg_wdata_d;
  logic ready_q, ready_d;
  logic cke_q, cke_d;
  logic cs_q, cs_d;
  logic [3:0] cmd_q, cmd_d;
  logic [5:0] ca_q, ca_d;
  logic pd_q, pd_d;
  logic oe_prev_q, oe_prev_d;
  logic rd_valid_q, rd_valid_d;
  logic [7:0] rd_data_q, rd_data_d;
  logic [7:0] cnt_q [NUM_K];
  logic [7:0] cnt_d [NUM_K];
  logic issue;
  logic may_issue;

  // ******************************************************
  // Issue and accept
  // ******************************************************
  always_comb begin
    state_d = state_q;
    pend_valid_d = pend_valid_q;
    pend_cmd_d = pend_cmd_q;
    pend_addr_d = pend_addr_q;
    pend_data_d = pend_data_q;
    term_d = term_q;
    reg_wdata_d = reg_wdata_q;
    cke_d = cke_q;
    pd_d = pd_q;
    cs_d = 1'b0;
    cmd_d = CMD_DES;
    ca_d = 6'h00;
    issue = 1'b0;
    // hold until the K_ANY counter and the pending command's own class counter have expired; in power-down only the exit issues
    may_issue = (cnt_q[K_ANY] == 8'h00) && (cnt_q[class_of(pend_cmd_q)] == 8'h00)
                && (pd_q == (pend_cmd_q == CMD_PDX));
    if (state_q == ST_REG_WRITE_DATA) begin
      // second beat carries the write data
      cs_d = 1'b1;
      cmd_d = CMD_REG_WRITE;
      ca_d = reg_wdata_q;
      state_d = ST_IDLE;
    end else if (pend_valid_q && !pd_q && (pend_cmd_q == CMD_PDX)) begin
      // Exit without a prior entry has nothing to do
      pend_valid_d = 1'b0;
    end else if (pend_valid_q && may_issue) begin
      issue = 1'b1;
      pend_valid_d = 1'b0;
      cs_d = 1'b1;
      cmd_d = pend_cmd_q;
      ca_d = pend_addr_q;
      if (pend_cmd_q == CMD_REG_WRITE) begin
        reg_wdata_d = pend_data_q;
        state_d = ST_REG_WRITE_DATA;
      end
      if (pend_cmd_q == CMD_PDE) begin
        cke_d = 1'b0;
        pd_d = 1'b1;
      end
      if (pend_cmd_q == CMD_PDX) begin
        cke_d = 1'b1;
        pd_d = 1'b0;
      end
    end
    if (req_valid_in && ready_q) begin
      pend_valid_d = 1'b1;
      pend_cmd_d = req_cmd_in;
      pend_addr_d = req_addr_in;
      pend_data_d = req_data_in;
      term_d = termination_enable_in;
    end
    ready_d = !pend_valid_d;
  end

  // ******************************************************
  // Spacing counters
  // ******************************************************
  genvar gk;
  generate
    for (gk = 0; gk < NUM_K; gk++) begin : g_cnt
      logic [7:0] dec;
      logic [7:0] ld;
      always_comb begin
        dec = (cnt_q[gk] == 8'h00) ? 8'h00 : cnt_q[gk] - 8'h01;
        ld = 8'(req_delay(pend_cmd_q, term_q, gk));
        ld = (ld == 8'h00) ? 8'h00 : ld - 8'h01;
        // one table serves both termination cases
        cnt_d[gk] = (issue && (ld > dec)) ? ld : dec;
      end
      always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          cnt_q[gk] <= 8'h00;
        end else begin
          cnt_q[gk] <= cnt_d[gk];
        end
      end
    end
  endgenerate

  // ******************************************************
  // Register read capture
  // ******************************************************
  always_comb begin
    oe_prev_d = link.dq_oe;
    // data sits in the first beats of the burst
    rd_valid_d = link.dq_oe && !oe_prev_q;
    rd_data_d = rd_valid_d ? link.dq : rd_data_q;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= ST_IDLE;
      pend_valid_q <= 1'b0;
      pend_cmd_q <= CMD_DES;
      pend_addr_q <= 6'h00;
      pend_data_q <= 6'h00;
      term_q <= 1'b0;
      reg_wdata_q <= 6'h00;
      ready_q <= 1'b0;
      cke_q <= 1'b1;
      cs_q <= 1'b0;
      cmd_q <= CMD_DES;
      ca_q <= 6'h00;
      pd_q <= 1'b0;
      oe_prev_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
    end else begin
      state_q <= state_d;
      pend_valid_q <= pend_valid_d;
      pend_cmd_q <= pend_cmd_d;
      pend_addr_q <= pend_addr_d;
      pend_data_q <= pend_data_d;
      term_q <= term_d;
      reg_wdata_q <= reg_wdata_d;
      ready_q <= ready_d;
      cke_q <= cke_d;
      cs_q <= cs_d;
      cmd_q <= cmd_d;
      ca_q <= ca_d;
      pd_q <= pd_d;
      oe_prev_q <= oe_prev_d;
      rd_valid_q <= rd_valid_d;
      rd_data_q <= rd_data_d;
    end
  end

  assign link.cke = cke_q;
  assign link.cs = cs_q;
  assign link.cmd = cmd_q;
  assign link.ca = ca_q;
  assign req_ready_out = ready_q;
  assign rd_valid_out = rd_valid_q;
  assign rd_data_out = rd_data_q;
  assign power_down_out = pd_q;

endmodule // mode_reg_controller

// ---- design/mode_reg_device.sv ----
`timescale 1ns/1ns
module mode_reg_device
  import mode_reg_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [5:0] reg_sel_in,
  output logic [5:0] reg_value_out,
  output logic [7:0] bank_active_out,
  output logic reg_busy_out,
  mode_reg_link_if.device link
);

  typedef enum logic [0:0] {
    DS_IDLE = 1'b0,
    DS_REG_WRITE_DATA = 1'b1
  } dev_state_t;

  function automatic logic read_only(input logic [5:0] addr);
    read_only = READ_ONLY_MASK[addr];
  endfunction

  // ******************************************************
  // State
  // ******************************************************
  dev_state_t state_q, state_d;
  logic [5:0] reg_waddr_q, reg_waddr_d;
  logic [5:0] regs_q [NUM_REGS];
  logic [5:0] regs_d [NUM_REGS];
  logic [7:0] bank_q, bank_d;
  // One slot per clock of latency but the last, which the output register adds, so reads one read period apart overlap safely
  logic rd_pipe_q [READ_LATENCY-1];
  logic rd_pipe_d [READ_LATENCY-1];
  logic [5:0] rd_addr_q [READ_LATENCY-1];
  logic [5:0] rd_addr_d [READ_LATENCY-1];
  logic rd_any;
  logic [7:0] beat_q, beat_d;
  logic oe_q, oe_d;
  logic [7:0] dq_q, dq_d;
  logic [5:0] value_q, value_d;
  logic busy_q, busy_d;
  logic cmd_seen;

  // ******************************************************
  // Command decode
  // ******************************************************
  always_comb begin
    state_d = state_q;
    reg_waddr_d = reg_waddr_q;
    regs_d = regs_q;
    bank_d = bank_q;
    rd_any = 1'b0;
    rd_pipe_d[0] = 1'b0;
    rd_addr_d[0] = 6'h00;
    for (int i = 1; i < READ_LATENCY - 1; i++) begin
      rd_pipe_d[i] = rd_pipe_q[i-1];
      rd_addr_d[i] = rd_addr_q[i-1];
    end
    beat_d = beat_q;
    oe_d = oe_q;
    dq_d = dq_q;
    cmd_seen = link.cke && link.cs;
    if (state_q == DS_REG_WRITE_DATA) begin
      state_d = DS_IDLE;
      if (cmd_seen && !read_only(reg_waddr_q)) begin
        regs_d[reg_waddr_q] = link.ca;
      end
    end else if (cmd_seen) begin
      case (link.cmd)
        // first beat carries the register address
        CMD_REG_WRITE: begin
          reg_waddr_d = link.ca;
          state_d = DS_REG_WRITE_DATA;
        end
        CMD_REG_READ: begin
          rd_pipe_d[0] = 1'b1;
          rd_addr_d[0] = link.ca;
        end
        // only row commands change bank state
        CMD_ACT: bank_d[link.ca[2:0]] = 1'b1;
        CMD_PRE: bank_d[link.ca[2:0]] = 1'b0;
        default: begin
        end
      endcase
    end
    // burst of sixteen, data held on low lines
    if (rd_pipe_q[READ_LATENCY-2]) begin
      oe_d = 1'b1;
      beat_d = 8'(REG_READ_BURST_CK - 1);
      dq_d = {2'h0, regs_q[rd_addr_q[READ_LATENCY-2]]};
    end else if (oe_q) begin
      if (beat_q == 8'h00) begin
        oe_d = 1'b0;
        dq_d = 8'h00;
      end else begin
        beat_d = beat_q - 8'h01;
      end
    end
    value_d = regs_q[reg_sel_in];
    for (int i = 0; i < READ_LATENCY - 1; i++) begin
      rd_any = rd_any | rd_pipe_d[i];
    end
    busy_d = rd_any || oe_d || (state_d == DS_REG_WRITE_DATA);
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= DS_IDLE;
      reg_waddr_q <= 6'h00;
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= REG_RESET_VALUE;
      end
      bank_q <= 8'h00;
      for (int i = 0; i < READ_LATENCY - 1; i++) begin
        rd_pipe_q[i] <= 1'b0;
        rd_addr_q[i] <= 6'h00;
      end
      beat_q <= 8'h00;
      oe_q <= 1'b0;
      dq_q <= 8'h00;
      value_q <= 6'h00;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      reg_waddr_q <= reg_waddr_d;
      regs_q <= regs_d;
      bank_q <= bank_d;
      rd_pipe_q <= rd_pipe_d;
      rd_addr_q <= rd_addr_d;
      beat_q <= beat_d;
      oe_q <= oe_d;
      dq_q <= dq_d;
      value_q <= value_d;
      busy_q <= busy_d;
    end
  end

  assign link.dq = dq_q;
  assign link.dq_oe = oe_q;
  assign reg_value_out = value_q;
  assign bank_active_out = bank_q;
  assign reg_busy_out = busy_q;

endmodule // mode_reg_device

// ---- verification/mode_reg_link_properties.sv ----
`timescale 1ns/1ns
module mode_reg_link_properties
  import mode_reg_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic cke,
  input wire logic cs,
  input wire logic [3:0] cmd,
  input wire logic [5:0] ca,
  input wire logic [7:0] dq,
  input wire logic dq_oe
);
  // ****
  // Cycles since each command class
  // ****
  localparam int READ_LAT_D = READ_LATENCY;
  localparam int WR_MIN = (WR_AFTER_RR_TERM_OFF < WR_AFTER_RR_TERM_ON) ? WR_AFTER_RR_TERM_OFF : WR_AFTER_RR_TERM_ON;
  logic [7:0] n_rd_q, n_rd_d, n_wr_q, n_wr_d, n_rr_q, n_rr_d, n_rw_q, n_rw_d, n_px_q, n_px_d;
  logic hi_q, hi_d, ck_q, ck_d;
  logic is_cmd, rd, wr, rr, rw, px;
  assign is_cmd = cke && cs;
  assign rd = is_cmd && (cmd == CMD_RD || cmd == CMD_RDA);
  assign wr = is_cmd && (cmd == CMD_WR || cmd == CMD_WRA);
  assign rr = is_cmd && cmd == CMD_REG_READ;
  assign rw = is_cmd && cmd == CMD_REG_WRITE && !hi_q;
  assign px = cke && (cs || !ck_q) && cmd == CMD_PDX;

  // Saturate so an old command never wraps back into range
  function automatic logic [7:0] nxt(input logic hit, input logic [7:0] q);
    nxt = hit ? 8'h01 : ((q == 8'hFF) ? q : q + 8'h01);
  endfunction

  always_comb begin
    hi_d = rw;
    ck_d = cke;
    n_rd_d = nxt(rd, n_rd_q);
    n_wr_d = nxt(wr, n_wr_q);
    n_rr_d = nxt(rr, n_rr_q);
    n_rw_d = nxt(rw, n_rw_q);
    n_px_d = nxt(px, n_px_q);
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hi_q <= 1'b0;
      ck_q <= 1'b1;
      n_rd_q <= 8'hFF;
      n_wr_q <= 8'hFF;
      n_rr_q <= 8'hFF;
      n_rw_q <= 8'hFF;
      n_px_q <= 8'hFF;
    end else begin
      hi_q <= hi_d;
      ck_q <= ck_d;
      n_rd_q <= n_rd_d;
      n_wr_q <= n_wr_d;
      n_rr_q <= n_rr_d;
      n_rw_q <= n_rw_d;
      n_px_q <= n_px_d;
    end
  end

  // ****
  // Properties
  // ****
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_rr_after_read: assert property (rr |-> n_rd_q >= RR_AFTER_RD)
    else $error("register read too soon after read");
  a_rr_after_write: assert property (rr |-> n_wr_q >= RR_AFTER_WR)
    else $error("register read too soon after write");
  a_rr_quiet_period: assert property (rr |=> (!cs) [*7])
    else $error("command inside register read period");
  a_rr_after_exit: assert property (rr |-> n_px_q >= RR_AFTER_PDX)
    else $error("register read too soon after power-down exit");
  a_rw_quiet_period: assert property (rw |=> (cs && cmd == CMD_REG_WRITE) ##1 (!cs) [*8])
    else $error("register write pair or quiet window broken");
  a_set_delay_kept: assert property ((rd || wr || rr) |-> n_rw_q >= REG_SET_DELAY_CK)
    else $error("access too soon after register write");
  a_wr_after_rr: assert property (wr |-> n_rr_q >= WR_MIN)
    else $error("write too soon after register read");
  a_rw_after_rr: assert property (rw |-> n_rr_q >= RW_AFTER_RR)
    else $error("register write too soon after register read");
  a_rw_after_read: assert property (rw |-> n_rd_q >= RW_AFTER_RD)
    else $error("register write too soon after read");
  a_rw_after_write: assert property (rw |-> n_wr_q >= RW_AFTER_WR)
    else $error("register write too soon after write");
  a_rr_data_burst: assert property (rr |-> ##READ_LAT_D dq_oe [*8])
    else $error("register read data burst missing");
  a_rr_data_upper: assert property (dq_oe |-> dq[7:6] == 2'b00)
    else $error("register read upper bits not zero");

  c_reg_read: cover property (rr);
  c_reg_write: cover property (rw);
  c_write_then_read: cover property (wr ##[1:30] rr);
endmodule // mode_reg_link_properties

// ---- verification/mode_register_access_timing_bench.sv ----
`timescale 1ns/1ns
module mode_register_access_timing_bench;
  import mode_reg_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic req_valid = 1'b0;
  logic [3:0] req_cmd = 4'h0;
  logic [5:0] req_addr = 6'h00;
  logic [5:0] req_data = 6'h00;
  logic [5:0] reg_sel = 6'h00;
  logic term_en = 1'b0;
  logic req_ready, rd_valid, power_down, reg_busy;
  logic [7:0] rd_data, bank_active, rd_seen;
  logic [5:0] reg_value;
  logic hi_q = 1'b0;
  logic ck_q = 1'b1;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int t_cur = 0;
  int t_prev = 0;
  int rd_count = 0;
  // ****
  // Pair table: first command, second command, termination, minimum gap
  // ****
  localparam logic [3:0] FA [17] = '{CMD_RD, CMD_WR, CMD_REG_READ, CMD_REG_WRITE, CMD_REG_READ,
    CMD_REG_WRITE, CMD_REG_READ, CMD_REG_READ, CMD_REG_READ, CMD_RD, CMD_RDA, CMD_WR, CMD_WRA,
    CMD_REG_WRITE, CMD_REG_WRITE, CMD_PDX, CMD_REG_READ};
  localparam logic [3:0] SB [17] = '{CMD_REG_READ, CMD_REG_READ, CMD_REG_READ, CMD_REG_READ, CMD_RD,
    CMD_RD, CMD_WR, CMD_WR, CMD_REG_WRITE, CMD_REG_WRITE, CMD_REG_WRITE, CMD_REG_WRITE, CMD_REG_WRITE,
    CMD_REG_WRITE, CMD_WR, CMD_REG_READ, CMD_REG_WRITE};
  localparam logic TM [17] = '{0, 0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 1};
  localparam int EX [17] = '{
    RR_AFTER_RD,
    RR_AFTER_WR,
    REG_READ_PERIOD_CK,
    REG_SET_DELAY_CK,
    REG_READ_PERIOD_CK,
    REG_SET_DELAY_CK,
    WR_AFTER_RR_TERM_OFF,
    WR_AFTER_RR_TERM_ON,
    RW_AFTER_RR,
    RW_AFTER_RD,
    RW_AFTER_RDA,
    RW_AFTER_WR,
    RW_AFTER_WRA,
    REG_WRITE_PERIOD_CK,
    REG_SET_DELAY_CK,
    RR_AFTER_PDX,
    RW_AFTER_RR};

  mode_reg_link_if link ();
  mode_reg_controller i_mode_reg_controller (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid),
    .req_cmd_in(req_cmd), .req_addr_in(req_addr), .req_data_in(req_data), .termination_enable_in(term_en),
    .req_ready_out(req_ready), .rd_valid_out(rd_valid), .rd_data_out(rd_data), .power_down_out(power_down),
    .link(link.controller));
  mode_reg_device i_mode_reg_device (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_sel_in(reg_sel),
    .reg_value_out(reg_value), .bank_active_out(bank_active), .reg_busy_out(reg_busy), .link(link.device));
  mode_reg_link_properties i_mode_reg_link_properties (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .cke(link.cke),
    .cs(link.cs), .cmd(link.cmd), .ca(link.ca), .dq(link.dq), .dq_oe(link.dq_oe));

  always #5 mclk_in = ~mclk_in;

  // Command times on the link; the data beat of a register write is not a new command
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    ck_q <= link.cke;
    hi_q <= link.cke && link.cs && link.cmd == CMD_REG_WRITE && !hi_q;
    if (rst_n_in && link.cke && (link.cs || !ck_q) && !hi_q) begin
      t_prev <= t_cur;
      t_cur <= cyc;
    end
    if (rd_valid === 1'b1) begin
      rd_seen <= rd_data;
      rd_count <= rd_count + 1;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    if (err_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Returns once the request is taken and its command is on the link
  task automatic send(input logic [3:0] c, input logic [5:0] a, input logic [5:0] d, input logic t);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_cmd <= c;
    req_addr <= a;
    req_data <= d;
    term_en <= t;
    @(posedge mclk_in);
    while (req_ready !== 1'b1 && n < 300) begin
      n++;
      @(posedge mclk_in);
    end
    req_valid <= 1'b0;
    @(posedge mclk_in);
    while (req_ready !== 1'b1 && n < 300) begin
      n++;
      @(posedge mclk_in);
    end
    if (n >= 300) check("request handshake", 1'b0, 1'b1);
  endtask

  initial begin
    repeat (20000) @(posedge mclk_in);
    err_count = err_count + 1;
    test_done();
  end

  initial begin
    int n;
    repeat (16) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    check("cke after reset", link.cke, 1'b1);
    check("banks after reset", bank_active, 8'h00);
    send(CMD_REG_WRITE, 6'h02, 6'h2A, 1'b0);
    send(CMD_REG_WRITE, 6'h05, 6'h15, 1'b0);
    reg_sel <= 6'h02;
    repeat (3) @(posedge mclk_in);
    check("writable register", reg_value, 6'h2A);
    reg_sel <= 6'h05;
    repeat (3) @(posedge mclk_in);
    check("read-only register", reg_value, 6'h00);
    send(CMD_ACT, 6'h03, 6'h00, 1'b0);
    send(CMD_REG_READ, 6'h02, 6'h00, 1'b0);
    n = rd_count;
    for (int i = 0; i < 60 && rd_count == n; i++) @(posedge mclk_in);
    check("register read data", rd_seen, 8'h2A);
    check("banks kept open", bank_active, 8'h08);
    for (int k = 0; k < 17; k++) begin
      if (FA[k] == CMD_PDX) begin
        send(CMD_PDE, 6'h00, 6'h00, 1'b0);
        check("power down entered", power_down, 1'b1);
      end
      send(FA[k], FA[k] == CMD_REG_WRITE ? 6'h03 : 6'h02, 6'h11, TM[k]);
      send(SB[k], SB[k] == CMD_REG_WRITE ? 6'h03 : 6'h02, 6'h11, TM[k]);
      // Let the command tracker record the second command before looking
      @(posedge mclk_in);
      check("command spacing", (t_cur - t_prev) >= EX[k], 1'b1);
    end
    check("banks after accesses", bank_active, 8'h08);
    send(CMD_PRE, 6'h03, 6'h00, 1'b0);
    repeat (3) @(posedge mclk_in);
    check("banks closed", bank_active, 8'h00);
    test_done();
  end
endmodule // mode_register_access_timing_bench
